// File: hdl/fsr_pkg.sv
// Purpose: shared constants of the fan speed regulation block
// Assumes: 200 MHz clock, temperatures in whole degrees C, duty in percent
// Notes:   register map sits on a 32-bit APB slave
package fsr_pkg;
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned CLK_KHZ        = CLK_HZ / 1000;
   // pwm frequency window and default
   localparam int unsigned PWM_MIN_KHZ    = 21;
   localparam int unsigned PWM_MAX_KHZ    = 28;
   localparam int unsigned PWM_TARGET_KHZ = 25;
   localparam logic [15:0] PERIOD_MIN =
      16'((CLK_KHZ + PWM_MAX_KHZ - 1) / PWM_MAX_KHZ);
   localparam logic [15:0] PERIOD_MAX = 16'(CLK_KHZ / PWM_MIN_KHZ);
   localparam logic [15:0] PERIOD_RST = 16'(CLK_KHZ / PWM_TARGET_KHZ);
   // timing
   localparam int unsigned SAMPLES_PER_S  = 4;
   localparam int unsigned SAMPLE_CYC     = CLK_HZ / SAMPLES_PER_S;
   localparam int unsigned SPINUP_MS      = 250;
   localparam int unsigned SPINUP_CYC     = CLK_KHZ * SPINUP_MS;
   localparam int unsigned SMOOTH_ATX_MS  = 35000;
   localparam int unsigned SMOOTH_BTX_MS  = 4000;
   localparam int unsigned DUTY_STEPS     = 80;
   localparam int unsigned STEP_ATX_CYC   =
      (CLK_KHZ / DUTY_STEPS) * SMOOTH_ATX_MS;
   localparam int unsigned STEP_BTX_CYC   =
      (CLK_KHZ / DUTY_STEPS) * SMOOTH_BTX_MS;
   // temperatures and duties
   localparam logic [7:0]  ATX_RAMP_DELTA = 8'h0A;
   localparam logic [7:0]  BTX_RAMP_DELTA = 8'h07;
   localparam logic [7:0]  ALL_ON_DELTA   = 8'h03;
   localparam logic [7:0]  AMB_RAMP_START = 8'h2F;
   localparam logic [7:0]  AMB_FULL_SPEED = 8'h36;
   localparam logic [7:0]  AMB_ALL_ON     = 8'h41;
   localparam logic [7:0]  HYST_PROC      = 8'h02;
   localparam logic [7:0]  HYST_AMB       = 8'h04;
   localparam logic [6:0]  DUTY_FULL      = 7'h64;
   localparam logic [6:0]  MIN_DUTY_RST   = 7'h14;
   localparam logic [7:0]  LIMIT_RST      = 8'h46;
   // register offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_PERIOD     = 8'h04;
   localparam logic [7:0]  OFS_LIMIT      = 8'h08;
   localparam logic [7:0]  OFS_MIN_DUTY   = 8'h0C;
   localparam logic [7:0]  OFS_CORR       = 8'h10;
   localparam logic [7:0]  OFS_STATUS     = 8'h14;
   // control and status bit positions
   localparam int unsigned CTRL_EN        = 0;
   localparam int unsigned CTRL_BTX       = 1;
   localparam int unsigned CTRL_AMB_EN    = 2;
   localparam int unsigned CTRL_LOCK      = 3;
   localparam int unsigned ST_SPINUP      = 24;
   localparam int unsigned ST_ALL_ON      = 25;
endpackage

// File: hdl/fsr_ramp.sv
// Purpose: one temperature zone: ramp to duty with hysteresis
// Assumes: temp_upd pulses once per fresh corrected reading
// Notes:   division is combinational; span is only a few degrees
`timescale 1ns/1ps
module fsr_ramp (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       temp_upd,
   input  wire logic [7:0] temp,
   input  wire logic [7:0] t_start,
   input  wire logic [7:0] t_full,
   input  wire logic [7:0] t_all_on,
   input  wire logic [7:0] hyst,
   input  wire logic [6:0] min_duty,
   output logic      [6:0] duty_q,
   output logic            all_on_q
);
   logic [7:0]  hold_t_q;
   logic [6:0]  duty_d;
   logic [7:0]  span;
   logic [14:0] prod;
   logic [14:0] frac;
   logic [6:0]  target;
   logic        slower_ok;

   assign span = t_full - t_start;
   assign prod = 15'((fsr_pkg::DUTY_FULL - min_duty) * (temp - t_start));
   assign frac = (span == 8'h00) ? 15'h0000 : prod / 15'(span);
   assign target =
      (temp >= t_full)  ? fsr_pkg::DUTY_FULL :            // [RQ5]
      (temp <= t_start) ? min_duty :                      // [RQ4]
      7'(min_duty + frac[6:0]);                   // [RQ6] [RQ15]
   // a slower duty waits until the zone has cooled by the band
   assign slower_ok = ({1'b0, temp} + {1'b0, hyst}) <= {1'b0, hold_t_q};
   assign duty_d = (target >= duty_q || slower_ok) ? target : duty_q; // [RQ7]

   always_ff @(posedge clk) begin
      if (!nrst) begin
         duty_q   <= fsr_pkg::DUTY_FULL;
         hold_t_q <= 8'hFF;
         all_on_q <= 1'b0;
      end else if (temp_upd) begin
         duty_q   <= duty_d;
         all_on_q <= temp >= t_all_on;                    // [RQ8]
         if (duty_d != duty_q) begin
            hold_t_q <= temp;
         end
      end
   end
endmodule // fsr_ramp

// File: hdl/fsr_pwm.sv
// Purpose: pwm waveform generator
// Assumes: period already clamped to the legal window
// Notes:   new period and duty take effect at the next period start
`timescale 1ns/1ps
module fsr_pwm (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic [15:0] period,
   input  wire logic [6:0]  duty,
   output logic             pwm_q
);
   logic [15:0] cnt_q;
   logic [15:0] thr_q;
   logic [15:0] per_q;
   logic        wrap;
   logic [22:0] prod;

   assign wrap = cnt_q >= per_q - 16'h0001;
   assign prod = 23'(period * duty);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q <= 16'h0000;
         per_q <= fsr_pkg::PERIOD_RST;
         thr_q <= 16'h0000;
         pwm_q <= 1'b0;
      end else begin
         cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
         if (wrap) begin
            per_q <= period;                              // [RQ1]
            thr_q <= 16'(prod / 23'(fsr_pkg::DUTY_FULL));
         end
         pwm_q <= run && (cnt_q < thr_q);
      end
   end
endmodule // fsr_pwm

// File: hdl/fsr_top.sv
// Purpose: fan speed regulation with two temperature zones and pwm drive
// Assumes: sensor interface logic runs on CLK and returns readings
//          some time after each sample request
// Notes:   settings are written by firmware over APB, then locked
//
// Function
// [RQ1] pwm frequency programmable anywhere within 21 to 28 kHz
// [RQ2] pwm frequency defaults to 25 kHz
// [RQ3] request diode readings at least four times per second
// [RQ4] below ramp start temperature hold the minimum duty, 20 percent
// [RQ5] drive 100 percent at full speed temperature, the control limit
// [RQ6] above ramp start raise duty; start is limit minus 10 or 7
// [RQ7] slow down only after cooling by 2 (processor) or 4 (ambient)
// [RQ8] all fans full at limit plus 3 or ambient 65
// [RQ9] spin-up at 100 percent for 250 ms on start
// [RQ10] ramp duty gradually over 35 s (ATX) or 4 s (BTX)
// [RQ11] drive fan with the higher of the two zone duties
// [RQ12] ambient zone ramps from 47 to 54 degrees
// [RQ13] firmware loads settings; lock stops later modification
// [RQ14] readings corrected by firmware offsets for ideality and resistance
// [RQ15] duty interpolates linearly between minimum and 100 percent
`timescale 1ns/1ps
module fsr_top #(
   parameter int unsigned SAMPLE_CYC   = fsr_pkg::SAMPLE_CYC,
   parameter int unsigned SPINUP_CYC   = fsr_pkg::SPINUP_CYC,
   parameter int unsigned STEP_ATX_CYC = fsr_pkg::STEP_ATX_CYC,
   parameter int unsigned STEP_BTX_CYC = fsr_pkg::STEP_BTX_CYC
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             SENSE_REQ,
   input  wire logic [7:0]  PROC_TEMP,
   input  wire logic        PROC_TEMP_VALID,
   input  wire logic [7:0]  AMB_TEMP,
   input  wire logic        AMB_TEMP_VALID,
   output logic             FAN_PWM
);
   // configuration registers
   logic [3:0]  ctrl_q;
   logic [15:0] period_q;
   logic [7:0]  limit_q;
   logic [6:0]  min_duty_q;
   logic [15:0] corr_q;
   logic [31:0] prdata_q;
   // measured and applied state
   logic [7:0]  proc_t_q;
   logic [7:0]  amb_t_q;
   logic        proc_upd_q;
   logic        amb_upd_q;
   logic [31:0] sample_cnt_q;
   logic        sense_q;
   logic [31:0] spin_cnt_q;
   logic        en_prev_q;
   logic [31:0] step_cnt_q;
   logic [6:0]  applied_q;
   logic [6:0]  applied_d;

   // bus decode
   logic        setup;
   logic        wr;
   logic        hit_ctrl;
   logic        hit_period;
   logic        hit_limit;
   logic        hit_min;
   logic        hit_corr;
   logic        hit_status;
   logic        mapped;
   logic        locked;
   logic        cfg_wr;
   logic [15:0] per_wr;
   logic [31:0] rd_mux;

   assign setup      = PSEL && !PENABLE;
   assign wr         = PSEL && PENABLE && PWRITE;
   assign hit_ctrl   = PADDR == fsr_pkg::OFS_CTRL;
   assign hit_period = PADDR == fsr_pkg::OFS_PERIOD;
   assign hit_limit  = PADDR == fsr_pkg::OFS_LIMIT;
   assign hit_min    = PADDR == fsr_pkg::OFS_MIN_DUTY;
   assign hit_corr   = PADDR == fsr_pkg::OFS_CORR;
   assign hit_status = PADDR == fsr_pkg::OFS_STATUS;
   assign mapped     = hit_ctrl | hit_period | hit_limit | hit_min |
                       hit_corr | hit_status;
   assign locked     = ctrl_q[fsr_pkg::CTRL_LOCK];
   assign cfg_wr     = wr && !locked;                     // [RQ13]
   // out-of-window periods clamp to the nearest legal edge
   assign per_wr =
      (PWDATA[15:0] < fsr_pkg::PERIOD_MIN) ? fsr_pkg::PERIOD_MIN :
      (PWDATA[15:0] > fsr_pkg::PERIOD_MAX) ? fsr_pkg::PERIOD_MAX :
      PWDATA[15:0];                                       // [RQ1]

   // registers answer at once, so no wait states are inserted
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA  = prdata_q;

   // zone thresholds
   logic        btx;
   logic        amb_en;
   logic        run;
   logic [7:0]  ramp_delta;
   logic [7:0]  proc_start;
   logic [7:0]  proc_all_on;
   logic [8:0]  all_on_sum;
   logic [6:0]  proc_duty;
   logic [6:0]  amb_duty;
   logic        proc_all_on_hit;
   logic        amb_all_on_hit;
   logic        all_on;
   logic [6:0]  target;
   logic        spinning;
   logic        step_tick;
   logic [31:0] step_lim;
   logic [6:0]  out_duty;

   assign btx        = ctrl_q[fsr_pkg::CTRL_BTX];
   assign amb_en     = ctrl_q[fsr_pkg::CTRL_AMB_EN];
   assign run        = ctrl_q[fsr_pkg::CTRL_EN];
   assign ramp_delta = btx ? fsr_pkg::BTX_RAMP_DELTA
                           : fsr_pkg::ATX_RAMP_DELTA;      // [RQ6]
   assign proc_start = (limit_q > ramp_delta) ? limit_q - ramp_delta
                                              : 8'h00;      // [RQ6]
   assign all_on_sum = {1'b0, limit_q} + {1'b0, fsr_pkg::ALL_ON_DELTA};
   assign proc_all_on = all_on_sum[8] ? 8'hFF : all_on_sum[7:0]; // [RQ8]

   // firmware offsets, signed, saturated into 0..255
   function automatic logic [7:0] corrected(input logic [7:0] raw,
                                            input logic [7:0] ofs);
      logic [9:0] s;
      s = {2'b00, raw} + {{2{ofs[7]}}, ofs};
      if (s[9]) begin
         corrected = 8'h00;
      end else if (s[8]) begin
         corrected = 8'hFF;
      end else begin
         corrected = s[7:0];
      end
   endfunction

   fsr_ramp u_proc (
      .clk      (CLK),
      .nrst     (NRST),
      .temp_upd (proc_upd_q),
      .temp     (proc_t_q),
      .t_start  (proc_start),
      .t_full   (limit_q),                                // [RQ5]
      .t_all_on (proc_all_on),
      .hyst     (fsr_pkg::HYST_PROC),                     // [RQ7]
      .min_duty (min_duty_q),
      .duty_q   (proc_duty),
      .all_on_q (proc_all_on_hit)
   );

   fsr_ramp u_amb (
      .clk      (CLK),
      .nrst     (NRST),
      .temp_upd (amb_upd_q),
      .temp     (amb_t_q),
      .t_start  (fsr_pkg::AMB_RAMP_START),                // [RQ12]
      .t_full   (fsr_pkg::AMB_FULL_SPEED),                // [RQ12]
      .t_all_on (fsr_pkg::AMB_ALL_ON),                    // [RQ8]
      .hyst     (fsr_pkg::HYST_AMB),                      // [RQ7]
      .min_duty (min_duty_q),
      .duty_q   (amb_duty),
      .all_on_q (amb_all_on_hit)
   );

   assign all_on = proc_all_on_hit || (amb_en && amb_all_on_hit); // [RQ8]
   assign target = (amb_en && amb_duty > proc_duty) ? amb_duty
                                                    : proc_duty; // [RQ11]
   assign spinning = spin_cnt_q != 32'h0000_0000;
   assign step_lim = btx ? STEP_BTX_CYC : STEP_ATX_CYC;   // [RQ10]
   assign step_tick = step_cnt_q >= step_lim - 32'h0000_0001;
   // one percent per step keeps a temperature spike from slamming the fan
   assign applied_d =
      !step_tick              ? applied_q :
      (applied_q < target)    ? applied_q + 7'h01 :
      (applied_q > target)    ? applied_q - 7'h01 :
      applied_q;                                          // [RQ10]
   assign out_duty = (spinning || all_on) ? fsr_pkg::DUTY_FULL
                                          : applied_q;    // [RQ8] [RQ9]

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[3:0] = ctrl_q;
      end else if (hit_period) begin
         rd_mux[15:0] = period_q;
      end else if (hit_limit) begin
         rd_mux[7:0] = limit_q;
      end else if (hit_min) begin
         rd_mux[6:0] = min_duty_q;
      end else if (hit_corr) begin
         rd_mux[15:0] = corr_q;
      end else if (hit_status) begin
         rd_mux[7:0]   = proc_t_q;
         rd_mux[15:8]  = amb_t_q;
         rd_mux[22:16] = out_duty;
         rd_mux[fsr_pkg::ST_SPINUP] = spinning;
         rd_mux[fsr_pkg::ST_ALL_ON] = all_on;
      end
   end

   // register file
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         ctrl_q     <= 4'h0;
         period_q   <= fsr_pkg::PERIOD_RST;                // [RQ2]
         limit_q    <= fsr_pkg::LIMIT_RST;
         min_duty_q <= fsr_pkg::MIN_DUTY_RST;              // [RQ4]
         corr_q     <= 16'h0000;
         prdata_q   <= 32'h0000_0000;
      end else begin
         if (setup && !PWRITE) begin
            prdata_q <= rd_mux;
         end
         if (cfg_wr && hit_ctrl) begin
            ctrl_q <= PWDATA[3:0];                        // [RQ13]
         end
         if (cfg_wr && hit_period) begin
            period_q <= per_wr;
         end
         if (cfg_wr && hit_limit) begin
            limit_q <= PWDATA[7:0];
         end
         if (cfg_wr && hit_min) begin
            min_duty_q <= (PWDATA[6:0] > fsr_pkg::DUTY_FULL) ?
                          fsr_pkg::DUTY_FULL : PWDATA[6:0];
         end
         if (cfg_wr && hit_corr) begin
            corr_q <= PWDATA[15:0];                       // [RQ14]
         end
      end
   end

   // sampling and reading capture
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sample_cnt_q <= 32'h0000_0000;
         sense_q      <= 1'b0;
         proc_t_q     <= 8'h00;
         amb_t_q      <= 8'h00;
         proc_upd_q   <= 1'b0;
         amb_upd_q    <= 1'b0;
      end else begin
         sense_q <= sample_cnt_q == 32'h0000_0000;        // [RQ3]
         sample_cnt_q <= (sample_cnt_q >= SAMPLE_CYC - 32'h0000_0001) ?
                         32'h0000_0000 : sample_cnt_q + 32'h0000_0001;
         proc_upd_q <= PROC_TEMP_VALID;
         amb_upd_q  <= AMB_TEMP_VALID;
         if (PROC_TEMP_VALID) begin
            proc_t_q <= corrected(PROC_TEMP, corr_q[7:0]);  // [RQ14]
         end
         if (AMB_TEMP_VALID) begin
            amb_t_q <= corrected(AMB_TEMP, corr_q[15:8]);   // [RQ14]
         end
      end
   end

   // spin-up and smoothing
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         en_prev_q  <= 1'b0;
         spin_cnt_q <= 32'h0000_0000;
         step_cnt_q <= 32'h0000_0000;
         applied_q  <= fsr_pkg::DUTY_FULL;
      end else begin
         en_prev_q <= run;
         if (run && !en_prev_q) begin
            spin_cnt_q <= SPINUP_CYC;                     // [RQ9]
         end else if (!run) begin
            spin_cnt_q <= 32'h0000_0000;
         end else if (spinning) begin
            spin_cnt_q <= spin_cnt_q - 32'h0000_0001;
         end
         step_cnt_q <= step_tick ? 32'h0000_0000
                                 : step_cnt_q + 32'h0000_0001;
         // after spin-up the fan eases down from full speed
         applied_q <= spinning ? fsr_pkg::DUTY_FULL : applied_d;
      end
   end

   assign SENSE_REQ = sense_q;

   fsr_pwm u_pwm (
      .clk    (CLK),
      .nrst   (NRST),
      .run    (run),
      .period (period_q),
      .duty   (out_duty),
      .pwm_q  (FAN_PWM)
   );
endmodule // fsr_top

// File: testbench/fsr_top_asserts.sv
// Purpose: port-level checks of the fan speed regulation block
// Assumes: one clock domain, zero-wait APB slave
// Notes:   shadows enable and lock from bus writes to judge the pwm pin
`timescale 1ns/1ps
module fsr_chk #(
   parameter int unsigned SAMPLE_CYC = 20
) (
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SENSE_REQ,
   input wire logic        FAN_PWM
);
   logic        en_q;
   logic        lock_q;
   int unsigned gap_q;
   int unsigned since_q;
   wire acc     = PSEL && PENABLE && PREADY;
   wire ctrl_wr = acc && PWRITE && PADDR == fsr_pkg::OFS_CTRL && !lock_q;
   wire st_rd   = acc && !PWRITE && PADDR == fsr_pkg::OFS_STATUS;
   // since_q starts saturated so the first rise after reset is not judged
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         en_q <= 1'b0;
         lock_q <= 1'b0;
         gap_q <= 0;
         since_q <= 32'hFFFF;
      end else begin
         if (ctrl_wr) begin
            en_q <= PWDATA[fsr_pkg::CTRL_EN];
            lock_q <= PWDATA[fsr_pkg::CTRL_LOCK];
         end
         gap_q <= SENSE_REQ ? 0 : gap_q + 1;
         if ($rose(FAN_PWM)) since_q <= 0;
         else if (since_q < 32'hFFFF) since_q <= since_q + 1;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   pready_high_a: assert property (PREADY)
      else $error("pready low");
   err_unmapped_a: assert property (PSEL && PENABLE
      && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > 8'h14))
      else $error("pslverr wrong");
   err_idle_a: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
      else $error("pslverr outside access");
   rdata_hold_a: assert property (!(PSEL && !PENABLE && !PWRITE)
      |=> $stable(PRDATA)) else $error("read data moved");
   req_pulse_a: assert property (SENSE_REQ |=> !SENSE_REQ)
      else $error("sample request too long");
   req_gap_a: assert property (gap_q < SAMPLE_CYC)
      else $error("sample request late");
   pwm_idle_a: assert property (!en_q [*3] |-> !FAN_PWM)
      else $error("pwm active while disabled");
   pwm_period_a: assert property ($rose(FAN_PWM)
      |-> since_q >= fsr_pkg::PERIOD_MIN - 1) else $error("pwm period short");
   spin_full_a: assert property (st_rd && PRDATA[fsr_pkg::ST_SPINUP]
      |-> PRDATA[22:16] == fsr_pkg::DUTY_FULL) else $error("spin-up duty");
   allon_full_a: assert property (st_rd && PRDATA[fsr_pkg::ST_ALL_ON]
      |-> PRDATA[22:16] == fsr_pkg::DUTY_FULL) else $error("all-on duty");
   duty_max_a: assert property (st_rd |-> PRDATA[22:16] <= 7'h64)
      else $error("duty above full");
endmodule // fsr_chk
bind fsr_top fsr_chk #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.CLK(CLK),
   .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .SENSE_REQ(SENSE_REQ), .FAN_PWM(FAN_PWM));

// File: testbench/fsr_sensor_model.sv
// Purpose: remote diode sensors answering each sample request
// Assumes: requests spaced further apart than the slow answer delay
// Notes:   data lines toggle outside a valid pulse so stale data is unusable
`timescale 1ns/1ps
module fsr_sensor_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       req,
   input  wire logic       slow,
   input  wire logic [7:0] proc_set,
   input  wire logic [7:0] amb_set,
   output logic      [7:0] proc_t,
   output logic            proc_v,
   output logic      [7:0] amb_t,
   output logic            amb_v
);
   logic [2:0] wait_q;
   always_ff @(posedge clk) begin
      proc_v <= 1'b0;
      amb_v <= 1'b0;
      if (!nrst) begin
         wait_q <= 3'h0;
         proc_t <= 8'h00;
         amb_t <= 8'h00;
      end else begin
         if (req) wait_q <= slow ? 3'h6 : 3'h1;
         else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
         // raw readings; ideality correction is left to the controller
         if (wait_q == 3'h1) begin
            proc_v <= 1'b1;
            amb_v <= 1'b1;
            proc_t <= proc_set;
            amb_t <= amb_set;
         end else begin
            proc_t <= ~proc_t;
            amb_t <= ~amb_t;
         end
      end
   end
endmodule // fsr_sensor_model

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the fan speed regulation block
// Assumes: shortened sample, spin-up and smoothing counts
// Notes:   reads queue their expectations; a monitor compares on completion
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;}
      fsr_exp_t;
   logic        clk, nrst, psel, penable, pwrite, slow;
   logic [7:0]  paddr, proc_set, amb_set, proc_t, amb_t;
   logic [31:0] pwdata, prdata, last_rd;
   logic        pready, pslverr, sense_req, proc_v, amb_v, fan_pwm;
   fsr_exp_t    exp_q[$];
   fsr_exp_t    cur;
   int          mismatches, check_count, cyc, hi, per;
   logic [7:0]  r;
   fsr_top #(.SAMPLE_CYC(20), .SPINUP_CYC(50), .STEP_ATX_CYC(10),
      .STEP_BTX_CYC(5)) dut (.CLK(clk), .NRST(nrst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SENSE_REQ(sense_req), .PROC_TEMP(proc_t), .PROC_TEMP_VALID(proc_v),
      .AMB_TEMP(amb_t), .AMB_TEMP_VALID(amb_v), .FAN_PWM(fan_pwm));
   fsr_sensor_model u_sns (.clk(clk), .nrst(nrst), .req(sense_req),
      .slow(slow), .proc_set(proc_set), .amb_set(amb_set), .proc_t(proc_t),
      .proc_v(proc_v), .amb_t(amb_t), .amb_v(amb_v));
   always #2.5 clk = ~clk;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input fsr_exp_t e);
      check_count++;
      if ((prdata & e.m) !== (e.d & e.m) || pslverr !== e.e) begin
         mismatches++;
         $display("MISMATCH t=%0t read %h err %b", $time, prdata, pslverr);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
      exp_q.push_back('{d, m, e});
      apb(1'b0, a, 32'h0);
   endtask
   // set both temperatures, let the zones settle, then check output duty
   task automatic step(input logic [7:0] p, input logic [7:0] a, input int w,
                       input logic [6:0] d);
      proc_set <= p;
      amb_set <= a;
      slow <= 1'($urandom_range(0, 1));
      repeat (w) @(posedge clk);
      rd(fsr_pkg::OFS_STATUS, {9'h0, d, 16'h0}, 32'h007F_0000, 1'b0);
   endtask
   task automatic pwm_meas;
      hi = 0;
      per = 0;
      while (fan_pwm !== 1'b0) @(posedge clk);
      while (fan_pwm !== 1'b1) @(posedge clk);
      while (fan_pwm === 1'b1) begin
         hi++;
         @(posedge clk);
      end
      per = hi;
      while (fan_pwm !== 1'b1) begin
         per++;
         @(posedge clk);
      end
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         last_rd = prdata;
         if (exp_q.size() == 0) chk_val(32'h1, 32'h0);
         else begin
            cur = exp_q.pop_front();
            chk_rd(cur);
         end
      end
   end
   // ceiling well above the roughly 25k cycles the sequence needs at most
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      r = 8'($urandom(34490));
      r = 8'($urandom_range(0, 59));
      proc_set = r;
      amb_set = 8'h1E;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(fsr_pkg::OFS_CTRL, 32'h0, 32'hFFFF_FFFF, 1'b0);
      rd(fsr_pkg::OFS_PERIOD, 32'(fsr_pkg::PERIOD_RST), 32'hFFFF,
         1'b0);
      rd(fsr_pkg::OFS_LIMIT, 32'(fsr_pkg::LIMIT_RST), 32'hFF, 1'b0);
      rd(fsr_pkg::OFS_MIN_DUTY, 32'h14, 32'h7F, 1'b0);
      rd(8'h18, 32'h0, 32'hFFFF_FFFF, 1'b1);
      wr(fsr_pkg::OFS_PERIOD, 32'h3E8);
      rd(fsr_pkg::OFS_PERIOD, 32'(fsr_pkg::PERIOD_MIN), 32'hFFFF,
         1'b0);
      wr(fsr_pkg::OFS_PERIOD, 32'h4E20);
      rd(fsr_pkg::OFS_PERIOD, 32'(fsr_pkg::PERIOD_MAX), 32'hFFFF,
         1'b0);
      wr(fsr_pkg::OFS_PERIOD, 32'(fsr_pkg::PERIOD_RST));
      wr(fsr_pkg::OFS_CTRL, 32'h1);
      rd(fsr_pkg::OFS_STATUS, 32'h0164_0000, 32'h037F_0000, 1'b0);
      repeat (60) @(posedge clk);
      rd(fsr_pkg::OFS_STATUS, 32'h0, 32'h0100_0000, 1'b0);
      step(r, 8'h1E, 1000, 7'h14);
      rd(fsr_pkg::OFS_STATUS, {24'h0, r}, 32'hFF, 1'b0);
      step(8'h3F, 8'h1E, 1000, 7'h2C);
      step(8'h44, 8'h1E, 1000, 7'h54);
      step(8'h43, 8'h1E, 1000, 7'h54);
      step(8'h42, 8'h1E, 1000, 7'h44);
      // mid-ramp: duty lies strictly between the old zone duty and full
      proc_set <= 8'h46;
      repeat (100) @(posedge clk);
      rd(fsr_pkg::OFS_STATUS, 32'h0, 32'h0300_0000, 1'b0);
      chk_val(32'(last_rd[22:16] > 7'h44), 1);
      chk_val(32'(last_rd[22:16] < 7'h64), 1);
      step(8'h46, 8'h1E, 1000, 7'h64);
      step(8'h32, 8'h1E, 1000, 7'h14);
      step(8'h49, 8'h1E, 60, 7'h64);
      rd(fsr_pkg::OFS_STATUS, 32'h0200_0000, 32'h0200_0000, 1'b0);
      wr(fsr_pkg::OFS_CORR, 32'h0000_00FE);
      wr(fsr_pkg::OFS_CTRL, 32'h7);
      step(8'h34, 8'h32, 1000, 7'h36);
      rd(fsr_pkg::OFS_STATUS, 32'h32, 32'hFF, 1'b0);
      step(8'h45, 8'h32, 1000, 7'h41);
      wr(fsr_pkg::OFS_PERIOD, 32'(fsr_pkg::PERIOD_MIN));
      pwm_meas();
      chk_val(per, 32'(fsr_pkg::PERIOD_MIN));
      chk_val(hi, 32'(fsr_pkg::PERIOD_MIN) * 65 / 100);
      step(8'h45, 8'h41, 60, 7'h64);
      rd(fsr_pkg::OFS_STATUS, 32'h0200_0000, 32'h0200_0000, 1'b0);
      wr(fsr_pkg::OFS_CTRL, 32'hF);
      wr(fsr_pkg::OFS_LIMIT, 32'h50);
      rd(fsr_pkg::OFS_LIMIT, 32'(fsr_pkg::LIMIT_RST), 32'hFF, 1'b0);
      stop_test();
   end
endmodule // tb_top
